// ===== dv/fwr_prot_model.sv
// protection functions model: sample stream and trigger levels
// assumes the bench asks for trigger levels through trig_req_i
`timescale 1ns/1ns
module fwr_prot_model
  import fwr_pkg::*;
(
  // clock
  input  wire logic                clk_i,
  // bench requests
  input  wire logic [NUM_TRIG-1:0] trig_req_i,
  // toward the recorder
  output fwr_pkg::fwr_sample_s     sample_o,
  output logic [NUM_TRIG-1:0]      trig_o
);
  initial begin
    sample_o = '0;
    trig_o   = '0;
  end
  // pattern moves every clock so a stale capture never matches
  always @(posedge clk_i) begin
    sample_o <= fwr_sample_s'(sample_o + 1'b1);
    trig_o   <= trig_req_i;
  end
endmodule

// ===== dv/fwr_top_asserts.sv
// checker: bus handshakes and sample strobe spacing of the recorder
// assumes it is bound to fwr_top and sees only its ports
`timescale 1ns/1ns
module fwr_top_asserts
  import fwr_pkg::*;
(
  input wire logic       CLK_I, RSTN_I, S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I,
  input wire logic       S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_BREADY_I, S_AXI_ARVALID_I,
  input wire logic       S_AXI_ARREADY_O, S_AXI_RVALID_O, S_AXI_RREADY_I, REC_WE_O, IRQ_O,
  input wire logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic [31:0] S_AXI_RDATA_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // saturating gap counter, so the first strobe after reset passes
  int gap;
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) gap <= SAMPLE_DIV;
    else if (REC_WE_O) gap <= 0;
    else if (gap < SAMPLE_DIV) gap <= gap + 1;
  end
  wire ar_hs = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  property p_b_hold; S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O); endproperty
  property p_r_hold; S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O); endproperty
  property p_r_lat; ar_hs |=> S_AXI_RVALID_O; endproperty
  property p_r_err; ar_hs && S_AXI_ARADDR_I > 8'h24 |=> S_AXI_RRESP_O == RESP_SLVERR; endproperty
  property p_b_lat;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O |-> ##[1:2] S_AXI_BVALID_O;
  endproperty
  property p_b_block; S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O; endproperty
  property p_we_pulse; REC_WE_O |=> !REC_WE_O; endproperty
  property p_we_gap; REC_WE_O |-> gap >= SAMPLE_DIV - 1; endproperty
  property p_irq_clr; ar_hs && S_AXI_ARADDR_I == REG_IRQ_STAT |-> ##[1:3] !IRQ_O; endproperty
  a_b_hold:   assert property (p_b_hold) else $error("bvalid dropped early");
  a_r_hold:   assert property (p_r_hold) else $error("rvalid dropped early");
  a_r_lat:    assert property (p_r_lat) else $error("read answer late");
  a_r_err:    assert property (p_r_err) else $error("unmapped read not refused");
  a_b_lat:    assert property (p_b_lat) else $error("write answer late");
  a_b_block:  assert property (p_b_block) else $error("ready during response");
  a_we_pulse: assert property (p_we_pulse) else $error("store write not a pulse");
  a_we_gap:   assert property (p_we_gap) else $error("sample strobes too close");
  a_irq_clr:  assert property (p_irq_clr) else $error("irq stays after status read");
  c_we:  cover property (REC_WE_O);
  c_irq: cover property ($rose(IRQ_O));
  c_err: cover property (S_AXI_RVALID_O && S_AXI_RRESP_O == RESP_SLVERR);
endmodule
bind fwr_top fwr_top_asserts u_chk (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
  .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .REC_WE_O(REC_WE_O), .IRQ_O(IRQ_O), .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
  .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_RDATA_O(S_AXI_RDATA_O));

// ===== dv/fwr_top_tb.sv
// testbench for the recorder: registers, manual and pin triggers, lock, delete
// assumes the protection model supplies samples and trigger levels
`timescale 1ns/1ns
module fwr_top_tb;
  import fwr_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00, trig_req = 8'h00;
  logic [31:0] wd = 32'h0;
  logic        awr, wr_rdy, bv, arr, rv, we, irq;
  logic [1:0]  br, rr;
  logic [31:0] rd_d;
  logic [7:0]  trig;
  logic [ADDR_W-1:0] wa;
  fwr_sample_s smp, rec_d;
  int          bad_count = 0, comparisons = 0;
  always #50 clk = ~clk;
  fwr_prot_model u_prot (.clk_i(clk), .trig_req_i(trig_req), .sample_o(smp), .trig_o(trig));
  fwr_top dut (.CLK_I(clk), .RSTN_I(rst_n), .SAMPLE_I(smp), .TRIG_I(trig), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_rdy), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rd_d), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready),
    .REC_WE_O(we), .REC_ADDR_O(wa), .REC_DATA_O(rec_d), .IRQ_O(irq));
  // ==========================================================================
  // shared tasks
  task automatic complete_run();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // address and data may be taken on different edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk) {awa, wd, awv, wv, bready} <= {a, d, 3'b111};
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awr) begin ad = 1'b1; awv <= 1'b0; end
      if (!dd && wr_rdy) begin dd = 1'b1; wv <= 1'b0; end
    end
    while (bv !== 1'b1) @(posedge clk);
    bready <= 1'b0;
    chk(br, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk) {ara, arv, rready} <= {a, 2'b11};
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge clk);
    d = rd_d;
    r = rr;
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(r, RESP_OKAY);
    chk(d, e);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 30000) begin @(posedge clk); n++; end
    chk(irq, 1'b1);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rdc(REG_MAXLEN, MAXLEN_RST);
    rdc(REG_PCT, PCT_RST);
    rdc(REG_COUNT, 32'h0);
    rd(8'h40, d, r);
    chk(r, RESP_SLVERR);
    wr(8'h40, 32'h0, RESP_SLVERR);
    wr(REG_MAXLEN, 32'h0003_FFFF, RESP_OKAY);
    rdc(REG_MAXLEN, MAXLEN_SAMPLES);
    wr(REG_PCT, 32'h0000_FFFF, RESP_OKAY);
    rdc(REG_PCT, 32'h0000_6464);
  endtask
  task automatic t_stream();
    logic [ADDR_W-1:0] a0;
    fwr_sample_s d0;
    int n;
    n = 0;
    while (we !== 1'b1) @(posedge clk);
    a0 = wa;
    d0 = rec_d;
    do begin
      @(posedge clk);
      n++;
    end while (we !== 1'b1 && n < 7000);
    chk(n, SAMPLE_DIV);
    chk(wa, a0 + 1'b1);
    chk(32'(rec_d - d0), SAMPLE_DIV);
  endtask
  task automatic t_manual();
    logic [31:0] d;
    logic [1:0] r;
    wr(REG_MAXLEN, 32'h2, RESP_OKAY);
    wr(REG_PCT, 32'h32, RESP_OKAY);
    wr(REG_IRQ_MASK, 32'h1, RESP_OKAY);
    wr(REG_CMD, 32'h1, RESP_OKAY);
    wait_irq();
    rdc(REG_IRQ_STAT, 32'h1);
    rdc(REG_IRQ_STAT, 32'h0);
    rd(REG_COUNT, d, r);
    chk($countones(d), 1);
  endtask
  task automatic t_lock();
    logic [31:0] d;
    logic [1:0] r;
    wr(REG_TRIG_EN, 32'h80, RESP_OKAY);
    @(posedge clk) trig_req <= 8'h80;
    wait_irq();
    rd(REG_STATUS, d, r);
    chk(d[2], 1'b1);
    rdc(REG_IRQ_STAT, 32'h1);
    @(posedge clk) trig_req <= 8'h00;
    repeat (6) @(posedge clk);
    rd(REG_STATUS, d, r);
    chk(d[2], 1'b0);
    rd(REG_COUNT, d, r);
    chk($countones(d), 2);
  endtask
  task automatic t_delete();
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] idx;
    idx = 4'h0;
    rd(REG_COUNT, d, r);
    for (int i = 15; i >= 0; i--) if (d[i]) idx = 4'(i);
    wr(REG_CMD, {20'h0, idx, 8'h02}, RESP_OKAY);
    rd(REG_COUNT, d, r);
    chk($countones(d), 1);
    rdc(REG_USED, 32'h2);
    wr(REG_CMD, 32'h6, RESP_OKAY);
    rdc(REG_COUNT, 32'h0);
    rdc(REG_USED, 32'h0);
  endtask
  // ==========================================================================
  // sequence and watchdog
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_stream();
    t_manual();
    t_lock();
    t_delete();
    complete_run();
  end
  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule

// ===== include/fwr_pkg.sv
// package for the fault waveform recorder: register map, fields, timing counts
// assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus
package fwr_pkg;

  // ==========================================================================
  // sampling
  localparam int          CLK_HZ            = 10_000_000;
  localparam int          FUND_HZ_DEF       = 50;
  localparam int          SAMPLES_PER_CYCLE = 32;
  localparam int          SAMPLE_HZ         = FUND_HZ_DEF * SAMPLES_PER_CYCLE;
  localparam int          SAMPLE_DIV        = CLK_HZ / SAMPLE_HZ;
  localparam int          NUM_ANALOG        = 4;
  localparam int          NUM_TRIG          = 8;
  localparam int          SAMPLE_W          = 16;

  // ==========================================================================
  // storage capacity in samples
  localparam int          STORE_SECONDS     = 120;
  localparam int          MAXLEN_SECONDS    = 15;
  localparam int          STORE_SAMPLES     = STORE_SECONDS * SAMPLE_HZ;
  localparam int          MAXLEN_SAMPLES    = MAXLEN_SECONDS * SAMPLE_HZ;
  localparam int          HIST_DEPTH        = 64;
  localparam int          HIST_AW           = 6;
  localparam int          ADDR_W            = 18;
  localparam int          NUM_REC           = 16;
  localparam int          REC_IDX_W         = 4;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0]  REG_CTRL          = 8'h00;
  localparam logic [7:0]  REG_MAXLEN        = 8'h04;
  localparam logic [7:0]  REG_PCT           = 8'h08;
  localparam logic [7:0]  REG_TRIG_EN       = 8'h0C;
  localparam logic [7:0]  REG_CMD           = 8'h10;
  localparam logic [7:0]  REG_STATUS        = 8'h14;
  localparam logic [7:0]  REG_COUNT         = 8'h18;
  localparam logic [7:0]  REG_USED          = 8'h1C;
  localparam logic [7:0]  REG_IRQ_STAT      = 8'h20;
  localparam logic [7:0]  REG_IRQ_MASK      = 8'h24;

  // ==========================================================================
  // fields
  localparam int          CTRL_OVERWRITE    = 0;
  localparam int          CMD_MANUAL        = 0;
  localparam int          CMD_DELETE        = 1;
  localparam int          CMD_DEL_ALL       = 2;
  localparam int          CMD_SEL_LSB       = 8;
  localparam int          IRQ_DONE          = 0;
  localparam int          IRQ_REFUSED       = 1;
  localparam int          IRQ_DROPPED       = 2;
  localparam int          IRQ_W             = 3;

  localparam logic [31:0] MAXLEN_RST        = 32'h0000_1F40;
  localparam logic [31:0] PCT_RST           = 32'h0000_1414;
  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EVENT = 2'b01,
    ST_POST  = 2'b10
  } fwr_rec_e;

  typedef struct packed {
    logic [NUM_ANALOG-1:0][SAMPLE_W-1:0] analog;
    logic [15:0]                         digital;
  } fwr_sample_s;

  typedef struct packed {
    logic [ADDR_W-1:0] start;
    logic [ADDR_W-1:0] length;
    logic [ADDR_W-1:0] trig_pos;
  } fwr_entry_s;

endpackage

// ===== rtl/fwr_axil.sv
// axi4-lite slave shell: one write and one read at a time
// assumes the register decode is combinational on the presented addresses
`timescale 1ns/1ns
module fwr_axil
  import fwr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // axi write
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  // axi read
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  // register side
  output logic             wr_o,
  output logic [7:0]       wr_addr_o,
  output logic [31:0]      wr_data_o,
  output logic [3:0]       wr_strb_o,
  input  wire logic        wr_ok_i,
  output logic             rd_o,
  output logic [7:0]       rd_addr_o,
  input  wire logic [31:0] rd_data_i,
  input  wire logic        rd_ok_i
);
  import fwr_pkg::*;

  typedef struct packed {
    logic        aw_have;
    logic [7:0]  aw;
    logic        w_have;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        awrdy;
    logic        wrdy;
    logic        ardy;
  } fwr_axs_s;

  fwr_axs_s s, next_s;

  // each channel taken independently; response once both are held
  always_comb begin
    next_s = s;
    if (awvalid_i && s.awrdy) begin
      next_s.aw_have = 1'b1;
      next_s.aw      = awaddr_i;
    end
    if (wvalid_i && s.wrdy) begin
      next_s.w_have = 1'b1;
      next_s.wd     = wdata_i;
      next_s.ws     = wstrb_i;
    end
    if (s.aw_have && s.w_have) begin
      next_s.aw_have = 1'b0;
      next_s.w_have  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = wr_ok_i ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.bvalid && bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (arvalid_i && s.ardy) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_data_i;
      next_s.rresp  = rd_ok_i ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rvalid && rready_i) begin
      next_s.rvalid = 1'b0;
    end
    // readies are registered so no bus output is a gate after the flops
    next_s.awrdy = !next_s.aw_have && !next_s.bvalid;
    next_s.wrdy  = !next_s.w_have && !next_s.bvalid;
    next_s.ardy  = !next_s.rvalid;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign awready_o = s.awrdy;
  assign wready_o  = s.wrdy;
  assign bvalid_o  = s.bvalid;
  assign bresp_o   = s.bresp;
  assign arready_o = s.ardy;
  assign rvalid_o  = s.rvalid;
  assign rdata_o   = s.rdata;
  assign rresp_o   = s.rresp;
  assign wr_o      = s.aw_have && s.w_have;
  assign wr_addr_o = s.aw;
  assign wr_data_o = s.wd;
  assign wr_strb_o = s.ws;
  assign rd_o      = arvalid_i && s.ardy;
  assign rd_addr_o = araddr_i;

endmodule

// ===== rtl/fwr_store.sv
// sample store: circular flip-flop window standing in for the record memory
// assumes the non-volatile backing sits behind this port in the real chip
`timescale 1ns/1ns
module fwr_store
  import fwr_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // write side
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] waddr_i,
  input  wire fwr_pkg::fwr_sample_s wdata_i,
  // read side
  input  wire logic [ADDR_W-1:0] raddr_i,
  output fwr_pkg::fwr_sample_s   rdata_o
);
  import fwr_pkg::*;

  // only the low address bits are kept in flip-flops; a real build maps the
  // whole address onto the retained memory so records survive power loss
  fwr_sample_s mem [HIST_DEPTH];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      if (we_i) begin
        mem[waddr_i[HIST_AW-1:0]] <= wdata_i;
      end
      rdata_o <= mem[raddr_i[HIST_AW-1:0]];
    end
  end

endmodule

// ===== rtl/fwr_top.sv
// fault waveform recorder: sampling, triggering, record bookkeeping, registers
// assumes trigger pins are asynchronous and sample inputs are on CLK_I
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module fwr_top
  import fwr_pkg::*;
(
  // clock and reset
  input  wire logic                       CLK_I,
  input  wire logic                       RSTN_I,
  // measured samples and trigger pins
  input  wire fwr_pkg::fwr_sample_s       SAMPLE_I,
  input  wire logic [NUM_TRIG-1:0]        TRIG_I,
  // axi4-lite write
  input  wire logic [7:0]                 S_AXI_AWADDR_I,
  input  wire logic                       S_AXI_AWVALID_I,
  output logic                            S_AXI_AWREADY_O,
  input  wire logic [31:0]                S_AXI_WDATA_I,
  input  wire logic [3:0]                 S_AXI_WSTRB_I,
  input  wire logic                       S_AXI_WVALID_I,
  output logic                            S_AXI_WREADY_O,
  output logic [1:0]                      S_AXI_BRESP_O,
  output logic                            S_AXI_BVALID_O,
  input  wire logic                       S_AXI_BREADY_I,
  // axi4-lite read
  input  wire logic [7:0]                 S_AXI_ARADDR_I,
  input  wire logic                       S_AXI_ARVALID_I,
  output logic                            S_AXI_ARREADY_O,
  output logic [31:0]                     S_AXI_RDATA_O,
  output logic [1:0]                      S_AXI_RRESP_O,
  output logic                            S_AXI_RVALID_O,
  input  wire logic                       S_AXI_RREADY_I,
  // store port and interrupt
  output logic                            REC_WE_O,
  output logic [ADDR_W-1:0]               REC_ADDR_O,
  output fwr_pkg::fwr_sample_s            REC_DATA_O,
  output logic                            IRQ_O
);
  import fwr_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [NUM_TRIG-1:0]     t1, t2, t3;
    logic [NUM_TRIG-1:0]     tq;
    logic [15:0]             div;
    logic                    overwrite;
    logic [ADDR_W-1:0]       maxlen;
    logic [7:0]              pre_pct, post_pct;
    logic [NUM_TRIG-1:0]     trig_en;
    logic                    man_req;
    fwr_rec_e                st;
    logic [NUM_TRIG-1:0]     cause;
    logic                    locked;
    logic [ADDR_W-1:0]       wptr;
    logic [ADDR_W-1:0]       cnt;
    logic [ADDR_W-1:0]       post_cnt;
    logic [ADDR_W-1:0]       rec_start, rec_trig;
    logic [NUM_REC-1:0]      valid;
    logic [REC_IDX_W-1:0]    head;
    logic [ADDR_W:0]         used;
    logic [IRQ_W-1:0]        irq_stat, irq_mask;
    logic                    irq;
    logic                    we;
    logic [ADDR_W-1:0]       waddr;
    fwr_sample_s             wdata;
  } fwr_top_s;

  fwr_top_s s, next_s;
  fwr_entry_s entries [NUM_REC];
  fwr_entry_s next_entry;
  logic       entry_we;
  logic [REC_IDX_W-1:0] entry_idx;
  logic [REC_IDX_W-1:0] del_idx;

  // register bus wiring
  logic        wr, rd, wr_ok, rd_ok;
  logic [7:0]  wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0]  wr_strb;

  // derived lengths
  logic [ADDR_W+7:0]   pre_prod, post_prod;
  logic [ADDR_W-1:0]   pre_len, post_len, ev_budget, rec_len;
  logic [NUM_TRIG-1:0] trig_live;
  logic                start, tick;

  fwr_axil u_axil (
    .clk_i     (CLK_I),
    .rst_n_i   (RSTN_I),
    .awaddr_i  (S_AXI_AWADDR_I),
    .awvalid_i (S_AXI_AWVALID_I),
    .awready_o (S_AXI_AWREADY_O),
    .wdata_i   (S_AXI_WDATA_I),
    .wstrb_i   (S_AXI_WSTRB_I),
    .wvalid_i  (S_AXI_WVALID_I),
    .wready_o  (S_AXI_WREADY_O),
    .bresp_o   (S_AXI_BRESP_O),
    .bvalid_o  (S_AXI_BVALID_O),
    .bready_i  (S_AXI_BREADY_I),
    .araddr_i  (S_AXI_ARADDR_I),
    .arvalid_i (S_AXI_ARVALID_I),
    .arready_o (S_AXI_ARREADY_O),
    .rdata_o   (S_AXI_RDATA_O),
    .rresp_o   (S_AXI_RRESP_O),
    .rvalid_o  (S_AXI_RVALID_O),
    .rready_i  (S_AXI_RREADY_I),
    .wr_o      (wr),
    .wr_addr_o (wr_addr),
    .wr_data_o (wr_data),
    .wr_strb_o (wr_strb),
    .wr_ok_i   (wr_ok),
    .rd_o      (rd),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_ok_i   (rd_ok)
  );

  fwr_store u_store (
    .clk_i   (CLK_I),
    .rst_n_i (RSTN_I),
    .we_i    (s.we),
    .waddr_i (s.waddr),
    .wdata_i (s.wdata),
    .raddr_i (s.wptr),
    .rdata_o ()
  );

  // ==========================================================================
  // lengths in samples
  always_comb begin
    pre_prod  = s.maxlen * s.pre_pct;
    post_prod = s.maxlen * s.post_pct;
    pre_len   = ADDR_W'(pre_prod / 100);
    post_len  = ADDR_W'(post_prod / 100);
    if (pre_len > s.maxlen) begin
      pre_len = s.maxlen;
    end
    ev_budget = s.maxlen - pre_len;
  end

  // a trigger counts once the second and third stages agree
  assign trig_live = s.t2 & s.t3 & s.trig_en;
  assign tick      = (s.div == 16'(SAMPLE_DIV - 1));
  // any newly asserted enabled trigger, or the operator request, while not locked
  assign start     = ((|(trig_live & ~s.tq)) || s.man_req) && !s.locked;
  assign rec_len   = s.cnt;
  assign del_idx   = wr_data[CMD_SEL_LSB+:REC_IDX_W];

  // ==========================================================================
  // register decode
  always_comb begin
    wr_ok   = 1'b1;
    rd_ok   = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      REG_CTRL:     rd_data = {31'h0, s.overwrite};
      REG_MAXLEN:   rd_data = 32'(s.maxlen);
      REG_PCT:      rd_data = {16'h0, s.post_pct, s.pre_pct};
      REG_TRIG_EN:  rd_data = {24'h0, s.trig_en};
      REG_STATUS:   rd_data = {16'h0, s.cause, 5'h0, s.locked, 2'(s.st)};
      REG_COUNT:    rd_data = {16'h0, s.valid};
      REG_USED:     rd_data = 32'(s.used);
      REG_IRQ_STAT: rd_data = {29'h0, s.irq_stat};
      REG_IRQ_MASK: rd_data = {29'h0, s.irq_mask};
      REG_CMD:      rd_data = 32'h0000_0000;
      default:      rd_ok   = 1'b0;
    endcase
    unique case (wr_addr)
      REG_CTRL, REG_MAXLEN, REG_PCT, REG_TRIG_EN, REG_CMD, REG_IRQ_MASK: wr_ok = 1'b1;
      REG_STATUS, REG_COUNT, REG_USED, REG_IRQ_STAT:                     wr_ok = 1'b1;
      default:                                                           wr_ok = 1'b0;
    endcase
  end

  // ==========================================================================
  // recorder
  always_comb begin
    next_s     = s;
    next_entry = '0;
    entry_we   = 1'b0;
    entry_idx  = s.head;
    next_s.t1  = TRIG_I;
    next_s.t2  = s.t1;
    next_s.t3  = s.t2;
    next_s.we  = 1'b0;
    next_s.div = tick ? 16'h0000 : s.div + 16'h0001;
    if (s.t2 == s.t3) begin
      next_s.tq = s.t2;
    end
    // continuous history ring; the circle is the whole shared area
    if (tick) begin
      next_s.we    = 1'b1;
      next_s.waddr = s.wptr;
      next_s.wdata = SAMPLE_I;
      next_s.wptr  = (s.wptr == ADDR_W'(STORE_SAMPLES - 1)) ? '0 : s.wptr + 1'b1;
    end
    // lock release in ST_IDLE once every causing input has gone
    if (s.locked && s.st == ST_IDLE && (s.cause & trig_live) == '0) begin
      next_s.locked = 1'b0;
    end
    unique case (s.st)
      ST_IDLE: begin
        if (start) begin
          if (s.valid[s.head] && !s.overwrite) begin
            next_s.irq_stat[IRQ_REFUSED] = 1'b1;
            next_s.locked                = 1'b1;
            next_s.cause                 = trig_live;
          end else begin
            next_s.st        = ST_EVENT;
            next_s.cause     = trig_live;
            next_s.locked    = 1'b1;
            // pre part always reaches back the full pre time
            next_s.rec_start = (s.wptr >= pre_len) ? s.wptr - pre_len
                               : s.wptr + ADDR_W'(STORE_SAMPLES) - pre_len;
            next_s.rec_trig  = s.wptr;
            next_s.cnt       = pre_len;
          end
        end
      end
      ST_EVENT: begin
        if (tick) begin
          next_s.cnt = s.cnt + 1'b1;
        end
        // event part ends with its causes or once max length minus pre time is used up
        if ((s.cause & trig_live) == '0 || s.cnt - (s.rec_trig - s.rec_start) >= ev_budget ||
            s.cnt >= s.maxlen) begin
          next_s.st       = ST_POST;
          next_s.cnt      = (s.cnt > s.maxlen) ? s.maxlen : s.cnt;
          next_s.post_cnt = '0;
        end
      end
      ST_POST: begin
        if (tick) begin
          next_s.cnt      = s.cnt + 1'b1;
          next_s.post_cnt = s.post_cnt + 1'b1;
        end
        // post part ends at post time or when the length budget is spent
        if (s.cnt >= s.maxlen || s.post_cnt >= post_len) begin
          next_s.st = ST_IDLE;
          entry_we  = 1'b1;
          next_entry.start    = s.rec_start;
          next_entry.length   = rec_len;
          next_entry.trig_pos = s.rec_trig;
          if (s.valid[s.head]) begin
            next_s.irq_stat[IRQ_DROPPED] = 1'b1;
            next_s.used = s.used - (ADDR_W+1)'(entries[s.head].length);
          end
          next_s.valid[s.head] = 1'b1;
          next_s.head          = s.head + 1'b1;
          next_s.used          = next_s.used + (ADDR_W+1)'(rec_len);
          next_s.irq_stat[IRQ_DONE] = 1'b1;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
    next_s.man_req = 1'b0;
    if (wr) begin
      unique case (wr_addr)
        REG_CTRL:     next_s.overwrite = wr_data[CTRL_OVERWRITE];
        REG_MAXLEN:   next_s.maxlen = (wr_data > 32'(MAXLEN_SAMPLES)) ? ADDR_W'(MAXLEN_SAMPLES)
                                      : wr_data[ADDR_W-1:0];
        REG_PCT: begin
          next_s.pre_pct  = (wr_data[7:0] > 8'h64) ? 8'h64 : wr_data[7:0];
          next_s.post_pct = (wr_data[15:8] > 8'h64) ? 8'h64 : wr_data[15:8];
        end
        REG_TRIG_EN:  next_s.trig_en = wr_data[NUM_TRIG-1:0];
        REG_IRQ_MASK: next_s.irq_mask = wr_data[IRQ_W-1:0];
        REG_CMD: begin
          next_s.man_req = wr_data[CMD_MANUAL];
          if (wr_data[CMD_DELETE]) begin
            if (wr_data[CMD_DEL_ALL]) begin
              next_s.valid = '0;
              next_s.used  = '0;
            end else if (s.valid[del_idx]) begin
              // give the slot's samples back to the shared budget
              next_s.valid[del_idx] = 1'b0;
              next_s.used           = next_s.used - (ADDR_W+1)'(entries[del_idx].length);
            end
          end
        end
        default: ;
      endcase
    end
    // read clears the bits it returns; an event in the same cycle survives only on a bit that was clear
    if (rd && rd_addr == REG_IRQ_STAT) begin
      next_s.irq_stat = next_s.irq_stat & ~s.irq_stat;
    end
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s          <= '0;
      s.maxlen   <= MAXLEN_RST[ADDR_W-1:0];
      s.pre_pct  <= PCT_RST[7:0];
      s.post_pct <= PCT_RST[15:8];
      s.st       <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // record list table, index by slot
  always_ff @(posedge CLK_I) begin
    if (entry_we) begin
      entries[entry_idx] <= next_entry;
    end
  end

  assign REC_WE_O   = s.we;
  assign REC_ADDR_O = s.waddr;
  assign REC_DATA_O = s.wdata;
  assign IRQ_O      = s.irq;

endmodule
